// file: led_flash_cfg_pkg.sv
package led_flash_cfg_pkg;

  // Register offsets on the serial register port.
  localparam logic [7:0] INPUT_MONITOR_CONFIG_ADDR = 8'h02;
  localparam logic [7:0] LED1_FLASH_LEVEL_ADDR = 8'h03;
  localparam logic [7:0] LED2_FLASH_LEVEL_ADDR = 8'h04;
  localparam logic [7:0] LED1_TORCH_LEVEL_ADDR = 8'h05;
  localparam logic [7:0] LED2_TORCH_LEVEL_ADDR = 8'h06;
  localparam logic [7:0] CONVERTER_CONFIG_ADDR = 8'h07;

  // Reset values.
  localparam logic [7:0] INPUT_MONITOR_CONFIG_RESET = 8'h01;
  localparam logic [7:0] LEVEL_RESET = 8'h7F;
  localparam logic [7:0] CONVERTER_CONFIG_RESET = 8'h09;

  // Field positions in the input monitor register.
  localparam int TORCH_RANGE_SELECT_BIT = 7;
  localparam int UVLO_ENABLE_BIT = 6;
  localparam int MONITOR_LEVEL_MSB = 5;
  localparam int MONITOR_LEVEL_LSB = 3;
  localparam int MONITOR_HYST_BIT = 2;
  localparam int MONITOR_MODE_MSB = 1;
  localparam int MONITOR_MODE_LSB = 0;

  // Field positions in the converter register.
  localparam int SOFT_RESET_BIT = 7;
  localparam int SHORT_DETECT_BIT = 3;
  localparam int PASS_MODE_BIT = 2;
  localparam int FREQ_SELECT_BIT = 1;
  localparam int CURRENT_LIMIT_BIT = 0;

  // Writable bits of the converter register; bits 6 to 4 read zero.
  localparam logic [7:0] CONVERTER_WRITE_MASK = 8'h0F;

  // Code where the brightness slope changes.
  localparam logic [7:0] SLOPE_BREAK_CODE = 8'h1F;

  // Operating modes.
  typedef enum logic [1:0]
  {
    MODE_STANDBY = 2'b00,
    MODE_IR = 2'b01,
    MODE_TORCH = 2'b10,
    MODE_FLASH = 2'b11
  } operating_mode_t;

  // Input monitor modes.
  typedef enum logic [1:0]
  {
    MON_OFF = 2'b00,
    MON_STOP_HOLD = 2'b01,
    MON_DOWN = 2'b10,
    MON_UP_DOWN = 2'b11
  } monitor_mode_t;

  // Decoded settings handed to the analog control.
  typedef struct packed
  {
    logic torchRangeSelect;
    logic undervoltageLockoutEnable;
    logic [2:0] inputMonitorLevel;
    logic inputMonitorHysteresis;
    monitor_mode_t inputMonitorMode;
  } monitor_cfg_t;

  typedef struct packed
  {
    logic ledShortDetectEnable;
    logic passModeOnly;
    logic converterFrequencySelect;
    logic converterCurrentLimit;
  } converter_cfg_t;

  // Four brightness channels: current in hundredths of a milliampere.
  typedef struct packed
  {
    logic [15:0] led1Flash;
    logic [15:0] led2Flash;
    logic [15:0] led1Torch;
    logic [15:0] led2Torch;
  } led_currents_t;

endpackage

// file: led_flash_config_registers.sv
// Overview of operation
// R1: Monitor bit 7 picks torch range, 0 wide to 510 mA, 1 narrow 360 mA.
// R2: Monitor bit 6 set enables undervoltage lockout; resets to disabled.
// R3: Monitor bits 5:3 set threshold 2.9 V to 3.6 V in 0.1 V steps.
// R4: Monitor bit 2 selects hysteresis, 0 none, 1 gives 50 mV.
// R5: Monitor bits 1:0: off, stop-and-hold default, down, up-and-down.
// R6: Monitor mode holds while operating; host returns to standby before changing it.
// R7: Flash codes 0 to 30 give 9.45 mA plus 8.04 mA per code.
// R8: Flash codes 31 to 255 give 28.34 mA plus 7.51 mA per code; the 16-bit result wraps from code 84 up.
// R9: Wide torch: 2.35 plus 2.11 per code, then 7.33 plus 1.97.
// R10: Narrow torch: 2 plus 1.5 per code, then 5.7 plus 1.4.
// R11: Four brightness registers are 8-bit read-write, resetting to 0x7F.
// R12: Writing 1 to converter bit 7 soft-resets fields; bit reads back zero.
// R13: Enable pin reset or soft reset restores all these fields to defaults.
// R14: Converter bit 3 enables LED short detection, default enabled.
// R15: Converter bit 2 at 1 forces pass mode; default normal operation.
// R16: Converter bit 1 selects 2 MHz at 0 or 4 MHz at 1.
// R17: Converter bit 0 selects 3.2 A at 0 or 3.9 A default.
// R18: Converter bits 6:4 read zero; register resets to 0x09.
// R19: Monitor register is 8 bits and resets to 0x01.
// R20: Mode field 00 standby, 01 IR, 10 torch, 11 flash; nonzero is enabled.
// R21: Monitor mode writes outside standby are discarded, keeping the old value.
`timescale 1ns/10ps
module led_flash_config_registers
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Enable pin level from outside, low holds the bank in reset.
  input wire logic hardwareEnablePin,
  // Operating mode from the enable register, same clock.
  input wire logic [1:0] operatingModeSelect,
  // Register port from the serial interface decoder, same clock.
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  output logic regHit,
  // Decoded settings.
  output led_flash_cfg_pkg::monitor_cfg_t monitorCfg,
  output led_flash_cfg_pkg::converter_cfg_t converterCfg,
  output led_flash_cfg_pkg::led_currents_t ledCurrents
);

  // Enable pin synchroniser.
  logic enableMeta_r;
  logic enableSync_r;

  // Stored register contents.
  logic [7:0] monitor_r;
  logic [7:0] led1Flash_r;
  logic [7:0] led2Flash_r;
  logic [7:0] led1Torch_r;
  logic [7:0] led2Torch_r;
  logic [3:0] converter_r;

  // Next value of the monitor register.
  logic [7:0] monitor_nxt;

  // Control decode.
  logic clearAll;
  logic softReset;
  logic deviceActive;
  logic narrowTorch;
  logic wrMonitor;
  logic wrLed1Flash;
  logic wrLed2Flash;
  logic wrLed1Torch;
  logic wrLed2Torch;
  logic wrConverter;

  // Current coefficients in units of 10 uA for flash, wide torch and narrow torch.
  localparam logic [15:0] FLASH_LOW_BASE = 16'h03B1;
  localparam logic [15:0] FLASH_LOW_STEP = 16'h0324;
  localparam logic [15:0] FLASH_HIGH_BASE = 16'h0B12;
  localparam logic [15:0] FLASH_HIGH_STEP = 16'h02EF;
  localparam logic [15:0] WIDE_LOW_BASE = 16'h00EB;
  localparam logic [15:0] WIDE_LOW_STEP = 16'h00D3;
  localparam logic [15:0] WIDE_HIGH_BASE = 16'h02DD;
  localparam logic [15:0] WIDE_HIGH_STEP = 16'h00C5;
  localparam logic [15:0] NARROW_LOW_BASE = 16'h00C8;
  localparam logic [15:0] NARROW_LOW_STEP = 16'h0096;
  localparam logic [15:0] NARROW_HIGH_BASE = 16'h023A;
  localparam logic [15:0] NARROW_HIGH_STEP = 16'h008C;

  // Piecewise current in hundredths of a milliampere.
  function automatic logic [15:0] levelCurrent(input logic [7:0] code, input logic [15:0] lowBase,
                                               input logic [15:0] lowStep, input logic [15:0] highBase,
                                               input logic [15:0] highStep);
    logic [15:0] result;
    if (code < led_flash_cfg_pkg::SLOPE_BREAK_CODE)
    begin
      result = 16'(lowBase + 16'(code) * lowStep);
    end
    else
    begin
      result = 16'(highBase + 16'(code) * highStep);
    end
    return result;
  endfunction

  // True when a write strobe targets the given offset.
  function automatic logic writeHits(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
    return strobe && (addr == target);
  endfunction

  // True when an offset falls inside this bank.
  function automatic logic isMapped(input logic [7:0] addr);
    return (addr >= led_flash_cfg_pkg::INPUT_MONITOR_CONFIG_ADDR)
           && (addr <= led_flash_cfg_pkg::CONVERTER_CONFIG_ADDR);
  endfunction

  // Torch current for either range; the range bit picks the coefficient set.
  function automatic logic [15:0] torchCurrent(input logic [7:0] code, input logic narrowRange);
    logic [15:0] result;
    if (narrowRange)
    begin
      result = levelCurrent(code, NARROW_LOW_BASE, NARROW_LOW_STEP, NARROW_HIGH_BASE, NARROW_HIGH_STEP); // R10
    end
    else
    begin
      result = levelCurrent(code, WIDE_LOW_BASE, WIDE_LOW_STEP, WIDE_HIGH_BASE, WIDE_HIGH_STEP); // R9
    end
    return result;
  endfunction

  // Flash current; both channels share one curve.
  function automatic logic [15:0] flashCurrent(input logic [7:0] code);
    return levelCurrent(code, FLASH_LOW_BASE, FLASH_LOW_STEP, FLASH_HIGH_BASE, FLASH_HIGH_STEP); // R7 R8
  endfunction

  // Two flip-flops bring the enable pin into the clock domain.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      enableMeta_r <= 1'b0;
      enableSync_r <= 1'b0;
    end
    else
    begin
      enableMeta_r <= hardwareEnablePin;
      enableSync_r <= enableMeta_r;
    end
  end

  // A soft reset is a write of one to converter bit 7; it is never stored.
  assign softReset = wrConverter && regWriteData[led_flash_cfg_pkg::SOFT_RESET_BIT]; // R12
  assign clearAll = !enableSync_r || softReset; // R13
  assign deviceActive = (operatingModeSelect != 2'(led_flash_cfg_pkg::MODE_STANDBY)); // R20

  // One write enable per register, decoded once.
  assign wrMonitor = writeHits(regWrite, regAddr, led_flash_cfg_pkg::INPUT_MONITOR_CONFIG_ADDR);
  assign wrLed1Flash = writeHits(regWrite, regAddr, led_flash_cfg_pkg::LED1_FLASH_LEVEL_ADDR);
  assign wrLed2Flash = writeHits(regWrite, regAddr, led_flash_cfg_pkg::LED2_FLASH_LEVEL_ADDR);
  assign wrLed1Torch = writeHits(regWrite, regAddr, led_flash_cfg_pkg::LED1_TORCH_LEVEL_ADDR);
  assign wrLed2Torch = writeHits(regWrite, regAddr, led_flash_cfg_pkg::LED2_TORCH_LEVEL_ADDR);
  assign wrConverter = writeHits(regWrite, regAddr, led_flash_cfg_pkg::CONVERTER_CONFIG_ADDR);

  // Range bit that picks the torch curve.
  assign narrowTorch = monitor_r[led_flash_cfg_pkg::TORCH_RANGE_SELECT_BIT]; // R1

  // Any offset inside the bank answers.
  assign regHit = isMapped(regAddr);

  // Next monitor value; the mode field is frozen while operating.
  always_comb
  begin
    monitor_nxt = regWriteData; // R1 R2 R3 R4 R5
    if (deviceActive)
    begin
      monitor_nxt[led_flash_cfg_pkg::MONITOR_MODE_MSB:led_flash_cfg_pkg::MONITOR_MODE_LSB] =
        monitor_r[led_flash_cfg_pkg::MONITOR_MODE_MSB:led_flash_cfg_pkg::MONITOR_MODE_LSB]; // R6 R21
    end
  end

  // Input monitor register.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || clearAll)
    begin
      monitor_r <= led_flash_cfg_pkg::INPUT_MONITOR_CONFIG_RESET; // R19
    end
    else if (wrMonitor)
    begin
      monitor_r <= monitor_nxt;
    end
  end

  // LED1 flash level register.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || clearAll)
    begin
      led1Flash_r <= led_flash_cfg_pkg::LEVEL_RESET; // R11
    end
    else if (wrLed1Flash)
    begin
      led1Flash_r <= regWriteData; // R11
    end
  end

  // LED2 flash level register.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || clearAll)
    begin
      led2Flash_r <= led_flash_cfg_pkg::LEVEL_RESET; // R11
    end
    else if (wrLed2Flash)
    begin
      led2Flash_r <= regWriteData; // R11
    end
  end

  // LED1 torch level register.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || clearAll)
    begin
      led1Torch_r <= led_flash_cfg_pkg::LEVEL_RESET; // R11
    end
    else if (wrLed1Torch)
    begin
      led1Torch_r <= regWriteData; // R11
    end
  end

  // LED2 torch level register.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || clearAll)
    begin
      led2Torch_r <= led_flash_cfg_pkg::LEVEL_RESET; // R11
    end
    else if (wrLed2Torch)
    begin
      led2Torch_r <= regWriteData; // R11
    end
  end

  // Converter register; only the low four bits are stored.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || clearAll)
    begin
      converter_r <= led_flash_cfg_pkg::CONVERTER_CONFIG_RESET[3:0]; // R18
    end
    else if (wrConverter)
    begin
      converter_r <= regWriteData[3:0]; // R14 R15 R16 R17
    end
  end

  // Read mux; the soft reset bit and reserved bits read zero.
  always_comb
  begin
    case (regAddr)
      led_flash_cfg_pkg::INPUT_MONITOR_CONFIG_ADDR: regReadData = monitor_r;
      led_flash_cfg_pkg::LED1_FLASH_LEVEL_ADDR: regReadData = led1Flash_r;
      led_flash_cfg_pkg::LED2_FLASH_LEVEL_ADDR: regReadData = led2Flash_r;
      led_flash_cfg_pkg::LED1_TORCH_LEVEL_ADDR: regReadData = led1Torch_r;
      led_flash_cfg_pkg::LED2_TORCH_LEVEL_ADDR: regReadData = led2Torch_r;
      led_flash_cfg_pkg::CONVERTER_CONFIG_ADDR:
        regReadData = {4'h0, converter_r} & led_flash_cfg_pkg::CONVERTER_WRITE_MASK; // R12 R18
      default:
      begin
        regReadData = 8'h00;
      end
    endcase
  end

  // Field breakout.
  always_comb
  begin
    monitorCfg.torchRangeSelect = monitor_r[led_flash_cfg_pkg::TORCH_RANGE_SELECT_BIT]; // R1
    monitorCfg.undervoltageLockoutEnable = monitor_r[led_flash_cfg_pkg::UVLO_ENABLE_BIT]; // R2
    monitorCfg.inputMonitorLevel =
      monitor_r[led_flash_cfg_pkg::MONITOR_LEVEL_MSB:led_flash_cfg_pkg::MONITOR_LEVEL_LSB]; // R3
    monitorCfg.inputMonitorHysteresis = monitor_r[led_flash_cfg_pkg::MONITOR_HYST_BIT]; // R4
    monitorCfg.inputMonitorMode = led_flash_cfg_pkg::monitor_mode_t'(
      monitor_r[led_flash_cfg_pkg::MONITOR_MODE_MSB:led_flash_cfg_pkg::MONITOR_MODE_LSB]); // R5
  end

  // Converter field breakout.
  always_comb
  begin
    converterCfg.ledShortDetectEnable = converter_r[led_flash_cfg_pkg::SHORT_DETECT_BIT]; // R14
    converterCfg.passModeOnly = converter_r[led_flash_cfg_pkg::PASS_MODE_BIT]; // R15
    converterCfg.converterFrequencySelect = converter_r[led_flash_cfg_pkg::FREQ_SELECT_BIT]; // R16
    converterCfg.converterCurrentLimit = converter_r[led_flash_cfg_pkg::CURRENT_LIMIT_BIT]; // R17
  end

  // Target currents in units of 10 uA; the torch curve follows the range bit.
  always_comb
  begin
    ledCurrents.led1Flash = flashCurrent(led1Flash_r); // R7 R8
    ledCurrents.led2Flash = flashCurrent(led2Flash_r); // R7 R8
    ledCurrents.led1Torch = torchCurrent(led1Torch_r, narrowTorch); // R9 R10
    ledCurrents.led2Torch = torchCurrent(led2Torch_r, narrowTorch); // R9 R10
  end

endmodule

// file: led_flash_config_registers_assertions.sv
`timescale 1ns/10ps
module led_flash_config_registers_assertions
(
  // Clock, reset and enable pin.
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hardwareEnablePin,
  // Register port.
  input wire logic [1:0] operatingModeSelect,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  input wire logic regHit,
  // Decoded settings.
  input wire led_flash_cfg_pkg::monitor_cfg_t monitorCfg,
  input wire led_flash_cfg_pkg::converter_cfg_t converterCfg,
  input wire led_flash_cfg_pkg::led_currents_t ledCurrents
);
  logic [1:0] pinSync_r;
  logic wr;
  // Copy of the pin synchroniser, so a write only counts once the bank listens.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      pinSync_r <= 2'h0;
    else
      pinSync_r <= {pinSync_r[0], hardwareEnablePin};
  end
  // A write that the bank must take.
  assign wr = regWrite && pinSync_r == 2'h3;
  // Flash current in 10 uA units, truncated to 16 bits like the outputs.
  function automatic logic [15:0] flashOf(input logic [7:0] c);
    return (c < 8'h1F) ? 16'h03B1 + 16'h0324 * c : 16'h0B12 + 16'h02EF * c;
  endfunction
  // Torch current for the wide or the narrow range.
  function automatic logic [15:0] torchOf(input logic [7:0] c, input logic n);
    if (n)
      return (c < 8'h1F) ? 16'h00C8 + 16'h0096 * c : 16'h023A + 16'h008C * c;
    return (c < 8'h1F) ? 16'h00EB + 16'h00D3 * c : 16'h02DD + 16'h00C5 * c;
  endfunction
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_monWr; wr && regAddr == 8'h02 |=> monitorCfg[7:2] == $past(regWriteData[7:2]); endproperty
  a_monWr: assert property (p_monWr) else $error("monitor fields not taken");
  property p_modeHold; wr && regAddr == 8'h02 && operatingModeSelect != 2'h0 |=> $stable(monitorCfg[1:0]); endproperty
  a_modeHold: assert property (p_modeHold) else $error("monitor mode changed while active");
  property p_modeTake;
    wr && regAddr == 8'h02 && operatingModeSelect == 2'h0 |=> monitorCfg[1:0] == $past(regWriteData[1:0]);
  endproperty
  a_modeTake: assert property (p_modeTake) else $error("monitor mode not taken");
  property p_soft;
    wr && regAddr == 8'h07 && regWriteData[7] |=> monitorCfg == 8'h01 && converterCfg == 4'h9;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset missed");
  property p_conv; wr && regAddr == 8'h07 && !regWriteData[7] |=> converterCfg == $past(regWriteData[3:0]); endproperty
  a_conv: assert property (p_conv) else $error("converter fields not taken");
  property p_rsvd; regAddr == 8'h07 |-> regHit && regReadData == {4'h0, converterCfg}; endproperty
  a_rsvd: assert property (p_rsvd) else $error("converter readback wrong");
  property p_pin; !hardwareEnablePin [*3] |=> monitorCfg == 8'h01 && converterCfg == 4'h9; endproperty
  a_pin: assert property (p_pin) else $error("pin low did not clear bank");
  property p_flash; regAddr == 8'h03 |-> ledCurrents.led1Flash == flashOf(regReadData); endproperty
  a_flash: assert property (p_flash) else $error("flash current wrong");
  property p_torch; regAddr == 8'h05 |-> ledCurrents.led1Torch == torchOf(regReadData, monitorCfg[7]); endproperty
  a_torch: assert property (p_torch) else $error("torch current wrong");
  property p_flash2; regAddr == 8'h04 |-> ledCurrents.led2Flash == flashOf(regReadData); endproperty
  a_flash2: assert property (p_flash2) else $error("second flash current wrong");
  property p_torch2; regAddr == 8'h06 |-> ledCurrents.led2Torch == torchOf(regReadData, monitorCfg[7]); endproperty
  a_torch2: assert property (p_torch2) else $error("second torch current wrong");
  c_soft: cover property (wr && regAddr == 8'h07 && regWriteData[7]);
  c_hold: cover property (wr && regAddr == 8'h02 && operatingModeSelect != 2'h0);
  c_pin: cover property (!hardwareEnablePin [*3]);
endmodule
bind led_flash_config_registers led_flash_config_registers_assertions i_chk (.clk_sys, .reset_n,
  .hardwareEnablePin, .operatingModeSelect, .regWrite, .regAddr, .regWriteData, .regReadData,
  .regHit, .monitorCfg, .converterCfg, .ledCurrents);

// file: led_flash_config_registers_tb.sv
`timescale 1ns/10ps
module led_flash_config_registers_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic hardwareEnablePin = 1'b0;
  logic regWrite, regHit;
  logic [1:0] operatingModeSelect;
  logic [7:0] regAddr, regWriteData, regReadData;
  led_flash_cfg_pkg::monitor_cfg_t monitorCfg;
  led_flash_cfg_pkg::converter_cfg_t converterCfg;
  led_flash_cfg_pkg::led_currents_t ledCurrents;
  logic [7:0] sh [0:8];
  logic [16:0] q [$];
  logic [16:0] e;
  int numErrors = 0;
  int nChecks = 0;
  int i;
  // 50 MHz system clock.
  always #10 clk_sys = ~clk_sys;
  led_flash_config_registers i_led_flash_config_registers (.clk_sys, .reset_n, .hardwareEnablePin,
    .operatingModeSelect, .regWrite, .regAddr, .regWriteData, .regReadData, .regHit, .monitorCfg,
    .converterCfg, .ledCurrents);
  led_host_model i_led_host_model (.clk_sys, .regWrite, .regAddr, .regWriteData, .operatingModeSelect);
  // Expected bank contents after any reset.
  task automatic dflt();
    sh = '{8'h00, 8'h00, 8'h01, 8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h09, 8'h00};
  endtask
  // Write through the host and track what the bank should now hold.
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_led_host_model.wr(a, d);
    if (a == 8'h07 && d[7])
      dflt();
    else if (a == 8'h07)
      sh[7] = {4'h0, d[3:0]};
    else if (a == 8'h02 && operatingModeSelect != 2'h0)
      sh[2] = {d[7:2], sh[2][1:0]};
    else if (a >= 8'h02 && a <= 8'h06)
      sh[a] = d;
  endtask
  // Read one offset and leave the expectation for the monitor.
  task automatic rd(input logic [7:0] a);
    i_led_host_model.look(a);
    q.push_back({a, a >= 8'h02 && a <= 8'h07, sh[a]});
  endtask
  // Compare the oldest expectation with the settled read port.
  always @(negedge clk_sys)
  begin
    if (q.size() > 0)
    begin
      e = q.pop_front();
      nChecks++;
      if ({regHit, regReadData} !== e[8:0])
      begin
        numErrors++;
        $display("MISMATCH reg %h exp %h got %h", e[16:9], e[8:0], {regHit, regReadData});
      end
    end
  end
  // Report and end the run.
  task automatic stopTest();
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog against a hang.
  initial
  begin
    #100us;
    numErrors++;
    stopTest();
  end
  // Main sequence.
  initial
  begin
    dflt();
    i = $urandom(44);
    repeat (12) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    hardwareEnablePin = 1'b1;
    for (i = 1; i <= 8; i++) rd(i[7:0]);
    for (i = 0; i < 12; i++)
    begin
      w(8'h03 + 8'(i % 4), i < 8 ? 8'h1E + 8'(i / 4) : 8'($urandom));
      rd(8'h03 + 8'(i % 4));
    end
    for (i = 0; i < 4; i++)
    begin
      w(8'h02, {i[1], 5'($urandom), i[1:0]});
      rd(8'h02);
      rd(8'h05);
      rd(8'h06);
    end
    for (i = 1; i < 4; i++)
    begin
      i_led_host_model.mode(i[1:0]);
      w(8'h02, {6'($urandom), ~sh[2][1:0]});
      rd(8'h02);
    end
    i_led_host_model.mode(2'h0);
    w(8'h07, 8'h76);
    rd(8'h07);
    w(8'h08, 8'hA5);
    rd(8'h08);
    w(8'h07, 8'hF6);
    for (i = 1; i <= 8; i++) rd(i[7:0]);
    w(8'h04, 8'h55);
    hardwareEnablePin = 1'b0;
    w(8'h03, 8'h33);
    dflt();
    repeat (3) @(posedge clk_sys);
    #1;
    hardwareEnablePin = 1'b1;
    repeat (3) @(posedge clk_sys);
    for (i = 1; i <= 8; i++) rd(i[7:0]);
    repeat (2) @(posedge clk_sys);
    stopTest();
  end
endmodule

// file: led_host_model.sv
`timescale 1ns/10ps
module led_host_model
(
  // Clock.
  input wire logic clk_sys,
  // Register port and operating mode towards the bank.
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [7:0] regWriteData,
  output logic [1:0] operatingModeSelect
);
  // Idle port at time zero.
  initial
  begin
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWriteData = 8'h00;
    operatingModeSelect = 2'h0;
  end
  // One write strobe, held over the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    regWrite = 1'b1;
    regAddr = a;
    regWriteData = d;
    @(posedge clk_sys);
    #1;
    regWrite = 1'b0;
    regWriteData = ~d; // Released data shows its inverse.
  endtask
  // Point the read port at an offset; data answers in the same cycle.
  task automatic look(input logic [7:0] a);
    @(posedge clk_sys);
    #1;
    regAddr = a;
    regWriteData = ~regWriteData;
  endtask
  // Change the operating mode.
  task automatic mode(input logic [1:0] m);
    @(posedge clk_sys);
    #1;
    operatingModeSelect = m;
  endtask
endmodule
